// file: rtl/iswc_regs.svh
`ifndef ISWC_REGS_SVH
`define ISWC_REGS_SVH
// Register byte offsets
`define ISWC_OFS_SWITCH 8'h00
`define ISWC_OFS_STAGED 8'h04
`define ISWC_OFS_GCFG 8'h08
`define ISWC_OFS_DSETUP 8'h0c
`define ISWC_OFS_INTERNAL_ERROR_REG 8'h10
`define ISWC_OFS_GLOBAL_ERROR_REG 8'h14
`define ISWC_OFS_COLL 8'h18
`define ISWC_OFS_CHAN0 8'h20
`define ISWC_OFS_CHAN7 8'h3c
// global_config bit positions
`define ISWC_GC_SOFTRST 0
`define ISWC_GC_RESYNC 1
`define ISWC_GC_FREEZE 2
`define ISWC_GC_LEDOFF 3
`define ISWC_GC_OPEN_LOAD_REPORT_SUPPRESS 4
`define ISWC_GC_EXT_RESET_DISABLE 5
// Channel diagnostic bit positions
`define ISWC_DG_OT 0
`define ISWC_DG_OLI 1
`define ISWC_DG_OLA 2
`define ISWC_DG_OCL 3
`define ISWC_DG_SCV 4
`define ISWC_DG_LED 5
// Timing, in ns (LED interval in ms) and derived cycles at 100 ns period
`define ISWC_CLK_NS 100
`define ISWC_SLOT_NS 5000
`define ISWC_SLOT_CYC (`ISWC_SLOT_NS / `ISWC_CLK_NS)
`define ISWC_HWRST_NS 100000
`define ISWC_HWRST_CYC ((`ISWC_HWRST_NS + `ISWC_CLK_NS - 1) / `ISWC_CLK_NS)
`define ISWC_LED_MS 100
`define ISWC_LED_CYC (`ISWC_LED_MS * 1000000 / `ISWC_CLK_NS)
// Phase of slot where the captured drive bits are applied to the outputs
`define ISWC_FWD_CYC 20
`define ISWC_NCAT 7
`endif

// file: rtl/iswc_pkg.sv
package iswc_pkg;
  typedef struct packed {
    logic [7:0] over_temp;
    logic [7:0] open_load_idle;
    logic [7:0] open_load_on;
    logic [7:0] overload_sense;
    logic [7:0] short_to_supply;
    logic [7:0] gated_led_status;
  } iswc_diag_t;
  typedef enum logic [2:0] {
    ISWC_HR_IDLE = 3'b001,
    ISWC_HR_TIME = 3'b010,
    ISWC_HR_ARMED = 3'b100
  } iswc_hr_state_t;
endpackage : iswc_pkg

// file: rtl/iswc_ctrl.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "iswc_regs.svh"
module iswc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic output_disable_n,
  input wire logic latch_strobe,
  input wire logic chip_select_n,
  input wire logic timing_strobe,
  input wire iswc_pkg::iswc_diag_t diag_in,
  input wire logic [7:0] internal_error_in,
  input wire logic [7:0] global_error_in,
  output logic [7:0] drive_out,
  output logic [2:0] slot_category,
  output logic slot_start
);
  import iswc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change counts when stages two and three agree
  logic [2:0] output_disable_n_s, ale_s, cs_s, ts_s;
  logic output_disable_n_q, ale_q, cs_q, ts_q, ts_prev;
  always_ff @(posedge aclk) begin
    output_disable_n_s <= {output_disable_n_s[1:0], output_disable_n};
    ale_s <= {ale_s[1:0], latch_strobe};
    cs_s <= {cs_s[1:0], chip_select_n};
    ts_s <= {ts_s[1:0], timing_strobe};
  end
  // Filtered levels; default inactive when not yet settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_disable_n_q <= 1'b1;
      ale_q <= 1'b0;
      cs_q <= 1'b1;
      ts_q <= 1'b1;
      ts_prev <= 1'b1;
    end else begin
      if (output_disable_n_s[1] == output_disable_n_s[2]) output_disable_n_q <= output_disable_n_s[2];
      if (ale_s[1] == ale_s[2]) ale_q <= ale_s[2];
      if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
      if (ts_s[1] == ts_s[2]) ts_q <= ts_s[2];
      ts_prev <= ts_q;
    end
  end
  wire ts_rise = ts_q && !ts_prev;
  wire ts_fall = !ts_q && ts_prev;

  ////////////////////////////////////////////////////////////////////////
  // Hardware reset qualification
  iswc_hr_state_t hr_state;
  logic [10:0] hr_cnt;
  logic hw_reset;
  logic [7:0] gcfg;
  wire hr_cond = ale_q && !cs_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !output_disable_n_q) begin
      hr_state <= ISWC_HR_IDLE;
      hr_cnt <= 11'h000;
      hw_reset <= 1'b0;
    end else begin
      hw_reset <= 1'b0;
      unique case (hr_state)
        ISWC_HR_IDLE: begin
          hr_cnt <= 11'h000;
          if (hr_cond && !gcfg[`ISWC_GC_EXT_RESET_DISABLE]) hr_state <= ISWC_HR_TIME;
        end
        ISWC_HR_TIME: begin
          if (!hr_cond) begin
            hr_state <= ISWC_HR_IDLE;
            hr_cnt <= 11'h000;
          end else if (hr_cnt == 11'(`ISWC_HWRST_CYC - 2)) begin
            hr_state <= ISWC_HR_ARMED;
          end else begin
            hr_cnt <= hr_cnt + 11'h001;
          end
        end
        ISWC_HR_ARMED: begin
          if (!hr_cond) begin
            hr_state <= ISWC_HR_IDLE;
            hw_reset <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset merge: hardware reset reloads everything, soft reset a subset
  logic soft_req;
  wire full_clr = !aresetn || !output_disable_n_q || hw_reset;
  wire part_clr = full_clr || soft_req;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path; address and data taken in either order
  logic aw_have, w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] sw_reg, staged, dsetup;
  wire do_wr = aw_have && w_have && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[7:2] <= `ISWC_OFS_DSETUP >> 2) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire wr_lane0 = do_wr && w_strb[0];
  wire wr_sw = wr_lane0 && aw_addr == `ISWC_OFS_SWITCH;
  wire wr_stg = wr_lane0 && aw_addr == `ISWC_OFS_STAGED;
  wire wr_gc = wr_lane0 && aw_addr == `ISWC_OFS_GCFG;
  wire wr_ds = wr_lane0 && aw_addr == `ISWC_OFS_DSETUP;
  wire resync = gcfg[`ISWC_GC_RESYNC];
  wire freeze = gcfg[`ISWC_GC_FREEZE] && !resync;

  // Configuration; soft reset bit self-clears on the same edge that it acts
  always_ff @(posedge aclk) begin
    if (full_clr) begin
      gcfg <= 8'h00;
    end else if (wr_gc) begin
      gcfg <= w_data[7:0];
    end else if (gcfg[`ISWC_GC_SOFTRST]) begin
      gcfg[`ISWC_GC_SOFTRST] <= 1'b0;
    end
  end
  assign soft_req = gcfg[`ISWC_GC_SOFTRST];

  // Drive, staged and setup registers
  always_ff @(posedge aclk) begin
    if (full_clr) staged <= 8'h00;
    else if (wr_stg) staged <= w_data[7:0];
  end
  always_ff @(posedge aclk) begin
    if (part_clr) begin
      sw_reg <= 8'h00;
      dsetup <= 8'h00;
    end else begin
      if (wr_sw) sw_reg <= w_data[7:0];
      else if (resync && !ts_q) sw_reg <= staged;
      if (wr_ds) dsetup <= w_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link slot timer; soft reset waits for slot end so the slot stays intact
  logic [5:0] slot_cnt;
  logic [2:0] cat;
  logic restart_pend, hold_fwd;
  logic [7:0] fwd;
  wire slot_end = slot_cnt == 6'(`ISWC_SLOT_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_reset) begin
      slot_cnt <= 6'h00;
      cat <= 3'h0;
      restart_pend <= 1'b0;
      hold_fwd <= 1'b0;
    end else begin
      if (soft_req) restart_pend <= 1'b1;
      if (resync && ts_fall) hold_fwd <= 1'b1;
      if (resync && ts_rise) begin
        slot_cnt <= 6'h00;
        hold_fwd <= 1'b0;
        cat <= 3'h0;
      end else if (slot_end) begin
        slot_cnt <= 6'h00;
        restart_pend <= 1'b0;
        cat <= (restart_pend || cat == 3'(`ISWC_NCAT - 1)) ? 3'h0 : cat + 3'h1;
      end else begin
        slot_cnt <= slot_cnt + 6'h01;
      end
    end
  end
  // Drive captured once per slot; isochronous low phase freezes it
  wire iso_hold = !resync && !ts_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_reset) begin
      fwd <= 8'h00;
    end else if (slot_cnt == 6'h00 && !iso_hold && !(resync && hold_fwd)) begin
      fwd <= sw_reg;
    end
  end
  // Outputs: drive applied after forward phase, disable overrides at once
  logic [7:0] drv_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_reset) drv_q <= 8'h00;
    else if (slot_cnt == 6'(`ISWC_FWD_CYC)) drv_q <= fwd;
  end
  always_ff @(posedge aclk or negedge output_disable_n) begin
    if (!output_disable_n) drive_out <= 8'h00;
    else if (!aresetn) drive_out <= 8'h00;
    else drive_out <= drv_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_category <= 3'h0;
      slot_start <= 1'b0;
    end else begin
      slot_category <= cat;
      slot_start <= slot_cnt == 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gated LED sampled every 100 ms; long count kept as a plain counter
  logic [19:0] led_cnt;
  logic [7:0] led_q;
  always_ff @(posedge aclk) begin
    if (full_clr) begin
      led_cnt <= 20'h00000;
      led_q <= 8'h00;
    end else if (led_cnt == 20'(`ISWC_LED_CYC - 1)) begin
      led_cnt <= 20'h00000;
      led_q <= diag_in.gated_led_status;
    end else begin
      led_cnt <= led_cnt + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky collectors per channel; set beats clear on a collective read, or on strobe rise when frozen
  logic [5:0] sticky [8];
  logic [5:0] chan [8];
  logic [7:0] coll, int_err, gl_err;
  logic rd_coll;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chan[i] = 6'h00;
    end
  end
  logic [5:0] raw [8];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      raw[i][`ISWC_DG_OT] = diag_in.over_temp[i];
      raw[i][`ISWC_DG_OLI] = diag_in.open_load_idle[i] && !gcfg[`ISWC_GC_OPEN_LOAD_REPORT_SUPPRESS];
      raw[i][`ISWC_DG_OLA] = diag_in.open_load_on[i] && !gcfg[`ISWC_GC_OPEN_LOAD_REPORT_SUPPRESS];
      raw[i][`ISWC_DG_OCL] = diag_in.overload_sense[i];
      raw[i][`ISWC_DG_SCV] = diag_in.short_to_supply[i];
      raw[i][`ISWC_DG_LED] = led_q[i] && !gcfg[`ISWC_GC_LEDOFF];
    end
  end
  logic [5:0] diag_vis [8];
  wire vis_update = freeze ? ts_rise : rd_coll;
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (part_clr) begin
        sticky[i] <= 6'h00;
        diag_vis[i] <= 6'h00;
      end else begin
        // Collect regardless of strobe; clear only what was delivered
        if (vis_update) sticky[i] <= raw[i];
        else sticky[i] <= sticky[i] | raw[i];
        if (vis_update) diag_vis[i] <= sticky[i] | raw[i];
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // Continuous mode mirrors the collectors; freeze shows the delivered view
      coll[i] = freeze ? |diag_vis[i][4:0] : |sticky[i][4:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (part_clr) begin
      int_err <= 8'h00;
      gl_err <= 8'h00;
    end else begin
      int_err <= int_err | internal_error_in;
      gl_err <= gl_err | global_error_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one cycle to answer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr >= `ISWC_OFS_CHAN0 && s_axi_araddr <= `ISWC_OFS_CHAN7) begin
      rd_mux = {26'h0000000, diag_vis[s_axi_araddr[4:2]]};
    end else begin
      unique case (s_axi_araddr)
        `ISWC_OFS_SWITCH: rd_mux = {24'h000000, sw_reg};
        `ISWC_OFS_STAGED: rd_mux = {24'h000000, staged};
        `ISWC_OFS_GCFG: rd_mux = {24'h000000, gcfg};
        `ISWC_OFS_DSETUP: rd_mux = {24'h000000, dsetup};
        `ISWC_OFS_INTERNAL_ERROR_REG: rd_mux = {24'h000000, int_err};
        `ISWC_OFS_GLOBAL_ERROR_REG: rd_mux = {24'h000000, gl_err};
        `ISWC_OFS_COLL: rd_mux = {24'h000000, coll};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end
  wire ar_ok = s_axi_araddr[1:0] == 2'b00 && (s_axi_araddr <= `ISWC_OFS_COLL ||
    (s_axi_araddr >= `ISWC_OFS_CHAN0 && s_axi_araddr <= `ISWC_OFS_CHAN7));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      rd_coll <= 1'b0;
    end else begin
      rd_coll <= 1'b0;
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= ar_ok ? 2'b00 : 2'b10;
        rd_coll <= s_axi_araddr == `ISWC_OFS_COLL;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence hr_held_s;
    hr_state == ISWC_HR_ARMED && hr_cond;
  endsequence
  hr_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hr_held_s ##1 !hr_cond |-> ##1 hw_reset) else $error("latched reset not processed");
  hr_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hr_state == ISWC_HR_TIME && !hr_cond && output_disable_n_q |=> hr_state == ISWC_HR_IDLE && hr_cnt == 11'h000)
    else $error("early release not abandoned");
  hr_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(hr_state == ISWC_HR_ARMED) |-> $past(hr_cnt) == 11'(`ISWC_HWRST_CYC - 2))
    else $error("reset armed too early");
  hr_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hr_state == ISWC_HR_IDLE && gcfg[`ISWC_GC_EXT_RESET_DISABLE] |=> hr_state == ISWC_HR_IDLE)
    else $error("reset timer ran while disabled");
  soft_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_req && !wr_gc |=> !soft_req && sw_reg == 8'h00) else $error("soft reset not self cleared");
  output_disable_n_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !output_disable_n_q |=> gcfg == 8'h00 && sw_reg == 8'h00 && drive_out == 8'h00) else $error("disable left state");
  slot_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    slot_end && !(resync && ts_rise) && !hw_reset |=> slot_cnt == 6'h00) else $error("slot length wrong");
  led_hide_a: assert property (@(posedge aclk) disable iff (!aresetn)
    gcfg[`ISWC_GC_LEDOFF] |-> raw[0][`ISWC_DG_LED] == 1'b0) else $error("led not suppressed");
  frz_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    freeze && !ts_q && !ts_prev && !part_clr |=> $stable(coll)) else $error("frozen view changed");
  iso_drv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    iso_hold && !hw_reset |=> $stable(fwd)) else $error("drive sent while isochronous");
endmodule : iswc_ctrl

// file: bench/iswc_host_model.sv
`timescale 1ns/1ns
module iswc_host_model (
  input wire logic aclk,
  output logic output_disable_n,
  output logic latch_strobe,
  output logic chip_select_n,
  output logic timing_strobe
);
  int low_cnt;
  ////////////////////////////////////////////////////////////////
  // Idle levels: outputs enabled, not selected, strobe high
  initial begin
    output_disable_n = 1'b1;
    latch_strobe = 1'b0;
    chip_select_n = 1'b1;
    timing_strobe = 1'b1;
    low_cnt = 0;
  end
  // Disable pulse never shorter than 5 us, so a short request is stretched
  task output_disable_n_pulse(input int cyc);
    @(posedge aclk);
    output_disable_n <= 1'b0;
    repeat ((cyc < 50) ? 50 : cyc) @(posedge aclk);
    output_disable_n <= 1'b1;
  endtask : output_disable_n_pulse
  // Reset request held for cyc cycles, then both pins released together
  task hw_req(input int cyc);
    @(posedge aclk);
    latch_strobe <= 1'b1;
    chip_select_n <= 1'b0;
    repeat (cyc) @(posedge aclk);
    latch_strobe <= 1'b0;
    chip_select_n <= 1'b1;
  endtask : hw_req
  // Timing strobe level, changed just after an edge
  task strobe(input logic lvl);
    @(posedge aclk);
    timing_strobe <= lvl;
  endtask : strobe
  // Guard: strobe never left low long enough to trip the far watchdog
  always @(posedge aclk) begin
    low_cnt <= timing_strobe ? 0 : low_cnt + 1;
    if (!timing_strobe && low_cnt == 2900) timing_strobe <= 1'b1;
  end
endmodule : iswc_host_model

// file: bench/tb_top.sv
`timescale 1ns/1ns
`include "iswc_regs.svh"
module tb_top;
  import iswc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} iswc_note_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, output_disable_n_n, lstb, cs_n, tstb, slot_start;
  logic [7:0] awaddr, araddr, ie, ge, drive_out, v;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] cat, slot_category;
  iswc_diag_t diag_in;
  iswc_note_t rq[$];
  iswc_note_t nt;
  logic [1:0] bq[$];
  int n_mismatch, tests_run, gap, i;
  ////////////////////////////////////////////////////////////////
  iswc_ctrl iswc_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .output_disable_n(output_disable_n_n),
    .latch_strobe(lstb), .chip_select_n(cs_n), .timing_strobe(tstb), .diag_in(diag_in),
    .internal_error_in(ie), .global_error_in(ge), .drive_out(drive_out), .slot_category(slot_category),
    .slot_start(slot_start));
  iswc_host_model iswc_host_model_inst (.aclk(aclk), .output_disable_n(output_disable_n_n), .latch_strobe(lstb),
    .chip_select_n(cs_n), .timing_strobe(tstb));
  // 100 ns period
  always #50 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task fail_to(input string what);
    n_mismatch++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    final_report();
  endtask : fail_to
  // Write: address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    bit done;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 0;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) done = 1;
    end
    bready <= 1'b0;
    if (!done) fail_to("write");
  endtask : wr
  // Read: expectation noted first, the monitor compares it
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff,
          input logic [1:0] r = 2'b00);
    bit done;
    @(posedge aclk);
    rq.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 0;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) done = 1;
    end
    rready <= 1'b0;
    if (!done) fail_to("read");
  endtask : rd
  task wait_drive(input logic [7:0] e, input int lim);
    for (int n = 0; n < lim && drive_out !== e; n++) @(posedge aclk);
    chk("drive_out", {24'h0, e}, {24'h0, drive_out});
  endtask : wait_drive
  task wait_slot(output int n);
    for (n = 1; n <= 200; n++) begin
      @(posedge aclk);
      if (slot_start === 1'b1) break;
    end
    if (n > 200) fail_to("slot_start");
  endtask : wait_slot
  task tdone(input string s);
    $display("Test %s finished, mismatches so far %0d", s, n_mismatch);
  endtask : tdone
  ////////////////////////////////////////////////////////////////
  // Monitor: each answer takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) begin
        chk("read note", 32'h0, 32'h1);
      end else begin
        nt = rq.pop_front();
        chk("rdata", nt.d & nt.m, rdata & nt.m);
        chk("rresp", {30'h0, nt.r}, {30'h0, rresp});
      end
    end
    if (bvalid && bready) chk("bresp", {30'h0, (bq.size() > 0) ? bq.pop_front() : 2'bxx}, {30'h0, bresp});
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, ie, ge, wdata} = '0;
    wstrb = 4'hf;
    diag_in = '0;
    void'($urandom(8980));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`ISWC_OFS_SWITCH, 0);
    rd(`ISWC_OFS_GCFG, 0);
    rd(8'h1c, 0, 0, 2'b10);
    wr(8'h1c, 1, 2'b10);
    tdone("reset values");
    // Slot length and category rotation
    for (i = 0; i < 9; i++) begin
      wait_slot(gap);
      if (i > 0) chk("slot gap", 50, gap);
      if (i > 0) chk("category", (cat + 1) % 7, {29'h0, slot_category});
      cat = slot_category;
    end
    tdone("slots");
    v = 8'($urandom) | 8'h81;
    wr(`ISWC_OFS_SWITCH, {24'h0, v});
    wait_drive(v, 120);
    tdone("drive");
    // Soft reset clears sticky errors and setup too
    ie <= 8'h05;
    ge <= 8'h30;
    repeat (4) @(posedge aclk);
    ie <= 8'h00;
    ge <= 8'h00;
    wstrb <= 4'he;
    wr(`ISWC_OFS_DSETUP, 8'h5a);
    wstrb <= 4'hf;
    rd(`ISWC_OFS_DSETUP, 0);
    wr(`ISWC_OFS_DSETUP, 1);
    rd(`ISWC_OFS_INTERNAL_ERROR_REG, 5);
    rd(`ISWC_OFS_GLOBAL_ERROR_REG, 8'h30);
    wr(`ISWC_OFS_GCFG, 1);
    rd(`ISWC_OFS_GCFG, 0);
    rd(`ISWC_OFS_SWITCH, 0);
    rd(`ISWC_OFS_INTERNAL_ERROR_REG, 0);
    rd(`ISWC_OFS_GLOBAL_ERROR_REG, 0);
    rd(`ISWC_OFS_DSETUP, 0);
    wait_drive(0, 120);
    tdone("soft reset");
    wr(`ISWC_OFS_SWITCH, 8'hff);
    wait_drive(8'hff, 120);
    wr(`ISWC_OFS_GCFG, 8'h08);
    fork
      iswc_host_model_inst.output_disable_n_pulse(60);
      begin
        @(negedge output_disable_n_n);
        #1;
        chk("drive_out", 0, {24'h0, drive_out});
      end
    join
    rd(`ISWC_OFS_SWITCH, 0);
    rd(`ISWC_OFS_GCFG, 0);
    tdone("output disable");
    // Fault on channel 0 plus LED on channel 3: LED stays out of collective
    diag_in.open_load_idle <= 8'h01;
    diag_in.gated_led_status <= 8'h08;
    repeat (5) @(posedge aclk);
    rd(`ISWC_OFS_COLL, 1);
    rd(`ISWC_OFS_CHAN0, 2);
    diag_in <= '0;
    rd(`ISWC_OFS_COLL, 0, 0);
    rd(`ISWC_OFS_COLL, 0);
    rd(`ISWC_OFS_CHAN0, 0);
    wr(`ISWC_OFS_GCFG, 8'h10);
    diag_in.open_load_idle <= 8'h02;
    diag_in.open_load_on <= 8'h02;
    diag_in.over_temp <= 8'h02;
    diag_in.overload_sense <= 8'h02;
    diag_in.short_to_supply <= 8'h02;
    repeat (5) @(posedge aclk);
    rd(`ISWC_OFS_COLL, 0, 0);
    rd(`ISWC_OFS_CHAN0 + 8'h04, 8'h19);
    diag_in <= '0;
    rd(`ISWC_OFS_COLL, 0, 0);
    rd(`ISWC_OFS_COLL, 0, 0);
    tdone("diagnostics");
    // Freeze: hidden fault and held drive while strobe is low
    wr(`ISWC_OFS_GCFG, 8'h04);
    iswc_host_model_inst.strobe(1'b0);
    repeat (5) @(posedge aclk);
    wr(`ISWC_OFS_SWITCH, 8'h3c);
    diag_in.over_temp <= 8'h04;
    repeat (120) @(posedge aclk);
    chk("drive_out", 0, {24'h0, drive_out});
    rd(`ISWC_OFS_COLL, 0);
    iswc_host_model_inst.strobe(1'b1);
    wait_drive(8'h3c, 150);
    rd(`ISWC_OFS_COLL, 4);
    diag_in <= '0;
    tdone("freeze");
    // Resync: staged value copied while low, sent after rise
    wr(`ISWC_OFS_GCFG, 8'h02);
    v = 8'($urandom) | 8'h81;
    wr(`ISWC_OFS_STAGED, {24'h0, v});
    iswc_host_model_inst.strobe(1'b0);
    repeat (80) @(posedge aclk);
    rd(`ISWC_OFS_SWITCH, {24'h0, v});
    chk("drive_out", 8'h3c, {24'h0, drive_out});
    iswc_host_model_inst.strobe(1'b1);
    wait_drive(v, 100);
    wr(`ISWC_OFS_GCFG, 0);
    tdone("resync");
    // Hardware reset: disabled, abandoned early, then carried out
    wr(`ISWC_OFS_SWITCH, 8'hff);
    wr(`ISWC_OFS_GCFG, 8'h20);
    iswc_host_model_inst.hw_req(1010);
    repeat (10) @(posedge aclk);
    rd(`ISWC_OFS_SWITCH, 8'hff);
    wr(`ISWC_OFS_GCFG, 0);
    iswc_host_model_inst.hw_req(900);
    repeat (10) @(posedge aclk);
    rd(`ISWC_OFS_SWITCH, 8'hff);
    iswc_host_model_inst.hw_req(1010);
    repeat (10) @(posedge aclk);
    rd(`ISWC_OFS_SWITCH, 0);
    wait_drive(0, 120);
    tdone("hardware reset");
    final_report();
  end
endmodule : tb_top
